// file: core/status_leds_and_soft_pins.sv
// The register addresses and register access over APB were left to the implementer.
`timescale 1ns/10ps
`include "led_pins_defines.svh"
module status_leds_and_soft_pins #(
  parameter int unsigned FLASH_CYCLES = `ACT_FLASH_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rx_frame_done,
  input wire logic rx_addr_match,
  input wire logic link_up,
  input wire led_pins_pkg::link_speed_e link_speed,
  input wire logic eeprom_load,
  input wire led_pins_pkg::pin_vec_t eeprom_pin_dir,
  input wire led_pins_pkg::pin_vec_t soft_defined_pin_in,
  output led_pins_pkg::pin_vec_t soft_defined_pin_out,
  output led_pins_pkg::pin_vec_t soft_defined_pin_oe_n,
  output logic [1:0] gp_int_cause,
  output logic rx_activity_led_n,
  output logic link_led_n,
  output logic speed_hundred_led_n,
  output logic speed_gigabit_led_n
);
  import led_pins_pkg::*;
  // Pin vector bits: [3:2] = pins 7:6, [1:0] = pins 1:0; pin five absent
  pin_vec_t pin_dir;
  pin_vec_t pin_data;
  pin_vec_t pin_level;
  pin_vec_t level_prev;
  logic [1:0] int_route;
  logic [1:0] int_cause;
  logic act_lit;

  // Bus decode; any mapped offset answers without wait states
  wire logic wr_en = psel && penable && pwrite;
  wire logic rd_en = psel && penable && !pwrite;
  wire logic sel_dir = (paddr == `OFS_PIN_DIR);
  wire logic sel_data = (paddr == `OFS_PIN_DATA);
  wire logic sel_level = (paddr == `OFS_PIN_LEVEL);
  wire logic sel_route = (paddr == `OFS_INT_ROUTE);
  wire logic sel_cause = (paddr == `OFS_INT_CAUSE);
  wire logic sel_link = (paddr == `OFS_LINK_STATUS);
  wire logic mapped = sel_dir || sel_data || sel_level || sel_route || sel_cause || sel_link;
  wire logic act_hit = rx_frame_done && rx_addr_match;
  // Edge on an upper pin that is an input and routed
  wire logic [1:0] pin_event = (pin_level[3:2] ^ level_prev[3:2]) & ~pin_dir[3:2] & int_route;
  // Cause write-one-to-clear; a new event wins over the clear
  wire logic [1:0] cause_clr = (wr_en && sel_cause) ? pwdata[1:0] : 2'h0;
  wire logic [1:0] next_cause = (int_cause & ~cause_clr) | pin_event;
  logic [31:0] rd_mux;

  // Unmapped offsets read as zero
  always_comb begin
    rd_mux = 32'h0;
    if (sel_dir) begin
      rd_mux = {28'h0, pin_dir};
    end else if (sel_data) begin
      rd_mux = {28'h0, pin_data};
    end else if (sel_level) begin
      rd_mux = {28'h0, pin_level};
    end else if (sel_route) begin
      rd_mux = {30'h0, int_route};
    end else if (sel_cause) begin
      rd_mux = {30'h0, int_cause};
    end else if (sel_link) begin
      rd_mux = {28'h0, link_speed, act_lit, link_up};
    end
  end

  // EEPROM load beats a bus write in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_dir <= `RST_PIN_DIR;
    end else if (eeprom_load) begin
      pin_dir <= eeprom_pin_dir;
    end else if (wr_en && sel_dir) begin
      pin_dir <= pwdata[3:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_data <= `RST_PIN_DATA;
      int_route <= `RST_INT_ROUTE;
      int_cause <= 2'h0;
      pin_level <= 4'h0;
      level_prev <= 4'h0;
      prdata <= 32'h0;
    end else begin
      if (wr_en && sel_data) begin
        pin_data <= pwdata[3:0];
      end
      if (wr_en && sel_route) begin
        int_route <= pwdata[1:0];
      end
      int_cause <= next_cause;
      // One stage only: pins are taken as synchronous to pclk
      pin_level <= soft_defined_pin_in;
      level_prev <= pin_level;
      // Read data holds until the next read
      if (rd_en) begin
        prdata <= rd_mux;
      end
    end
  end

  // A new address-matched frame restarts the flash, so steady traffic stays lit
  led_flash #(
    .CYCLES(FLASH_CYCLES)
  ) u_act_flash (
    .pclk(pclk),
    .presetn(presetn),
    .trigger(act_hit),
    .lit(act_lit)
  );

  // Access phase answers immediately; no wait states
  assign pready = psel && penable;
  assign pslverr = psel && penable && !mapped;
  // Enable low means driving; only pins set as outputs drive
  assign soft_defined_pin_oe_n = ~pin_dir;
  assign soft_defined_pin_out = pin_data;
  assign gp_int_cause = int_cause;
  // Indicators pull low to light; link ones follow the inputs directly
  assign rx_activity_led_n = !act_lit;
  assign link_led_n = !link_up;
  assign speed_hundred_led_n = !(link_up && link_speed == speed_hundred);
  assign speed_gigabit_led_n = !(link_up && link_speed == speed_gigabit);
  // pin five intentionally has no port here

  // Indicator checks
  act_flash_a: assert property (@(posedge pclk) disable iff (!presetn)
    act_hit |=> !rx_activity_led_n)
    else $error("activity LED not lit");
  act_ignore_a: assert property (@(posedge pclk) disable iff (!presetn)
    rx_frame_done && !rx_addr_match && rx_activity_led_n |=> rx_activity_led_n)
    else $error("foreign frame lit LED");
  // Only a qualifying frame may light a dark activity LED
  act_quiet_a: assert property (@(posedge pclk) disable iff (!presetn)
    rx_activity_led_n && !act_hit |=> rx_activity_led_n)
    else $error("activity LED lit without frame");
  link_led_a: assert property (@(posedge pclk) disable iff (!presetn)
    link_led_n == !link_up)
    else $error("link LED mismatch");
  hundred_led_a: assert property (@(posedge pclk) disable iff (!presetn)
    !speed_hundred_led_n |-> link_up && link_speed == speed_hundred)
    else $error("hundred LED wrong");
  hundred_on_a: assert property (@(posedge pclk) disable iff (!presetn)
    link_up && link_speed == speed_hundred |-> !speed_hundred_led_n)
    else $error("hundred LED dark");
  gigabit_led_a: assert property (@(posedge pclk) disable iff (!presetn)
    !speed_gigabit_led_n |-> link_up && link_speed == speed_gigabit)
    else $error("gigabit LED wrong");
  gigabit_on_a: assert property (@(posedge pclk) disable iff (!presetn)
    link_up && link_speed == speed_gigabit |-> !speed_gigabit_led_n)
    else $error("gigabit LED dark");

  // Pin direction and data checks
  reset_input_a: assert property (@(posedge pclk)
    !presetn ##1 !presetn |-> soft_defined_pin_oe_n == 4'hf)
    else $error("pins not inputs in reset");
  dir_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && sel_dir && !eeprom_load |=> soft_defined_pin_oe_n == ~$past(pwdata[3:0]))
    else $error("direction write lost");
  dir_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    !eeprom_load && !(wr_en && sel_dir) |=> $stable(soft_defined_pin_oe_n))
    else $error("direction changed unasked");
  eeprom_dir_a: assert property (@(posedge pclk) disable iff (!presetn)
    eeprom_load |=> pin_dir == $past(eeprom_pin_dir))
    else $error("EEPROM override lost");
  out_drive_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && sel_data |=> soft_defined_pin_out == $past(pwdata[3:0]))
    else $error("pin data not driven");
  data_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    !(wr_en && sel_data) |=> $stable(soft_defined_pin_out))
    else $error("pin data changed unasked");
  level_read_a: assert property (@(posedge pclk) disable iff (!presetn)
    rd_en && sel_level |=> prdata[3:0] == $past(soft_defined_pin_in, 2))
    else $error("pin level read wrong");

  // Interrupt cause checks; a new event wins over a clear
  cause_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    pin_event[0] |=> gp_int_cause[0])
    else $error("interrupt cause missed");
  cause_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    gp_int_cause[0] && !(wr_en && sel_cause && pwdata[0]) |=> gp_int_cause[0])
    else $error("interrupt cause dropped");
  cause_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && sel_cause && pwdata[0] && !pin_event[0] |=> !gp_int_cause[0])
    else $error("interrupt cause not cleared");
  output_quiet_a: assert property (@(posedge pclk) disable iff (!presetn)
    pin_dir[2] && !gp_int_cause[0] |=> !gp_int_cause[0])
    else $error("output pin raised cause");
  unrouted_quiet_a: assert property (@(posedge pclk) disable iff (!presetn)
    !int_route[0] && !gp_int_cause[0] |=> !gp_int_cause[0])
    else $error("unrouted pin raised cause");

  // Main scenarios
  act_cover: cover property (@(posedge pclk) act_hit);
  gig_cover: cover property (@(posedge pclk) !speed_gigabit_led_n);
  hundred_cover: cover property (@(posedge pclk) !speed_hundred_led_n);
  eeprom_cover: cover property (@(posedge pclk) eeprom_load);
  cause_cover: cover property (@(posedge pclk) pin_event != 2'h0);
endmodule

// file: core/led_pins_defines.svh
`ifndef LED_PINS_DEFINES_SVH
`define LED_PINS_DEFINES_SVH
// Register byte offsets
`define OFS_PIN_DIR 12'h000
`define OFS_PIN_DATA 12'h004
`define OFS_PIN_LEVEL 12'h008
`define OFS_INT_ROUTE 12'h00c
`define OFS_INT_CAUSE 12'h010
`define OFS_LINK_STATUS 12'h014
// Reset values
`define RST_PIN_DIR 4'h0
`define RST_PIN_DATA 4'h0
`define RST_INT_ROUTE 2'h0
// Activity flash length
`define ACT_FLASH_NS 50000000
`define ACT_FLASH_CYCLES ((`ACT_FLASH_NS + 4) / 5)
`endif

// file: core/led_pins_pkg.sv
package led_pins_pkg;
  typedef enum logic [1:0] {speed_ten, speed_hundred, speed_gigabit} link_speed_e;
  typedef logic [3:0] pin_vec_t;
endpackage

// file: core/led_flash.sv
`timescale 1ns/10ps
module led_flash #(
  parameter int unsigned CYCLES = 10000000
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic trigger,
  output logic lit
);
  logic [31:0] count;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= 32'h0;
    end else if (trigger) begin
      count <= CYCLES[31:0];
    end else if (count != 32'h0) begin
      count <= count - 32'h1;
    end
  end
  assign lit = (count != 32'h0);
endmodule

// file: bench/board_model.sv
`timescale 1ns/10ps
module board_model (
  input wire led_pins_pkg::pin_vec_t pin_out,
  input wire led_pins_pkg::pin_vec_t pin_oe_n,
  input wire led_pins_pkg::pin_vec_t board_drv,
  output led_pins_pkg::pin_vec_t pin_level
);
  import led_pins_pkg::*;
  // Board drives only the pins that the device has let go
  assign pin_level = (pin_out & ~pin_oe_n) | (board_drv & pin_oe_n);
endmodule

// file: bench/status_leds_and_soft_pins_bench.sv
`timescale 1ns/10ps
module status_leds_and_soft_pins_bench;
  import led_pins_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, e;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 0, prdata;
  logic pready, pslverr, act_n, link_n, h_n, g_n;
  logic rx_frame_done = 0, rx_addr_match = 0, link_up = 0, eeprom_load = 0;
  link_speed_e link_speed = speed_ten;
  pin_vec_t eeprom_pin_dir = 4'h0, drv = 4'h0, pin_in, pin_out, oe_n, d;
  logic [1:0] cause;
  integer num_errors = 0, n_tests = 0, seed = 94361, cyc = 0;
  logic [32:0] exp_q[$];
  always #2.5 pclk = ~pclk;
  status_leds_and_soft_pins #(.FLASH_CYCLES(4)) DUT (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_frame_done(rx_frame_done),
    .rx_addr_match(rx_addr_match), .link_up(link_up), .link_speed(link_speed),
    .eeprom_load(eeprom_load), .eeprom_pin_dir(eeprom_pin_dir), .soft_defined_pin_in(pin_in),
    .soft_defined_pin_out(pin_out), .soft_defined_pin_oe_n(oe_n), .gp_int_cause(cause),
    .rx_activity_led_n(act_n), .link_led_n(link_n), .speed_hundred_led_n(h_n),
    .speed_gigabit_led_n(g_n));
  board_model board (.pin_out(pin_out), .pin_oe_n(oe_n), .board_drv(drv), .pin_level(pin_in));
  task finish_test;
    $display("errors %0d checks %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task chk(input logic [32:0] seen, input logic [32:0] exp, input string what);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd, input logic [32:0] ex);
    @(posedge pclk);
    psel <= 1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    if (!wr) exp_q.push_back(ex);
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 0;
    penable <= 0;
  endtask
  task frame(input logic m);
    @(posedge pclk);
    rx_frame_done <= 1;
    rx_addr_match <= m;
    @(posedge pclk);
    rx_frame_done <= 0;
    #1;
  endtask
  // Read results land with the access edge; bit 32 carries the error flag
  always @(posedge pclk) begin
    cyc++;
    if (cyc > 3000) begin
      num_errors++;
      finish_test();
    end else if (psel && penable && pready && !pwrite) begin
      e = pslverr;
      #1 chk({e, prdata}, exp_q.pop_front(), "read");
    end
  end
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1;
    #1 chk(oe_n, 4'hf, "oe_n");
    chk(act_n, 1, "act_n");
    for (int s = 0; s < 3; s++) begin
      @(posedge pclk);
      link_up <= 1;
      link_speed <= link_speed_e'(s);
      #1 chk({link_n, h_n, g_n}, {1'b0, s != 1, s != 2}, "link leds");
    end
    @(posedge pclk);
    link_up <= 0;
    #1 chk({link_n, h_n, g_n}, 3'h7, "link down");
    // Status word: speed in [3:2], flash in [1], link in [0]
    apb(0, 12'h014, 0, 33'h8);
    d = 4'($random(seed));
    apb(1, 12'h004, {28'h0, d}, 0);
    apb(0, 12'h004, 0, {29'h0, d});
    apb(1, 12'h000, 32'hf, 0);
    apb(0, 12'h008, 0, {29'h0, d});
    apb(0, 12'h000, 0, 33'hf);
    @(posedge pclk);
    eeprom_pin_dir <= 4'h3;
    eeprom_load <= 1;
    @(posedge pclk);
    eeprom_load <= 0;
    apb(0, 12'h000, 0, 33'h3);
    apb(1, 12'h00c, 32'h1, 0);
    apb(0, 12'h00c, 0, 33'h1);
    // Pin seven toggles too but is not routed
    drv <= 4'hc;
    repeat (4) @(posedge pclk);
    #1 chk(cause, 2'h1, "cause");
    apb(0, 12'h010, 0, 33'h1);
    apb(1, 12'h010, 32'h1, 0);
    apb(0, 12'h010, 0, 33'h0);
    apb(0, 12'h018, 0, 33'h100000000);
    frame(0);
    chk(act_n, 1, "act other");
    frame(1);
    chk(act_n, 0, "act ours");
    // Four-cycle flash: still lit three edges on, dark at the fourth
    repeat (3) @(posedge pclk);
    #1 chk(act_n, 0, "act held");
    @(posedge pclk);
    #1 chk(act_n, 1, "act end");
    // Second reset mid-run: pins fall back to inputs
    @(posedge pclk);
    presetn <= 0;
    #1 chk(oe_n, 4'hf, "oe_n reset");
    repeat (2) @(posedge pclk);
    presetn <= 1;
    apb(0, 12'h000, 0, 33'h0);
    finish_test();
  end
endmodule
